//--- iprs_defines.svh
// Constants for the interrupt priority and reset source block.
`ifndef IPRS_DEFINES_SVH
`define IPRS_DEFINES_SVH

// Number of interrupt numbers in the natural order table, 0 to 53.
`define IPRS_NUM_SRC 54
// Width of one user priority field and of the nibble that holds it.
`define IPRS_PRI_W 3
`define IPRS_NIB_W 4
// Number of priority configuration words, four fields in each.
`define IPRS_NUM_CFG 14
`define IPRS_CFG_IDX_W 4
// Reset value of every user priority field.
`define IPRS_PRI_RST 3'h4
// Disabled level and the highest level.
`define IPRS_PRI_OFF 3'h0
`define IPRS_PRI_MAX 3'h7
// Vector number is the interrupt number plus this offset.
`define IPRS_VEC_OFS 8'h08
// Interrupt numbers that exist; all others are reserved.
`define IPRS_IMPL_MASK 54'h0_0980_0BFF_FFFF
// Interrupt numbers fed by external pins.
`define IPRS_EXT0_NUM 0
`define IPRS_EXT1_NUM 16
`define IPRS_EXT2_NUM 23
// Program addresses of the reset jump and of its target word.
`define IPRS_BOOT_ADDR 24'h00_0000
`define IPRS_TGT_ADDR 24'h00_0002

`endif

//--- iprs_pkg.sv
// Types shared by the interrupt priority and reset source block.
`default_nettype none
package iprs_pkg;

  // Request presented to the core.
  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
    logic [2:0] level;
  } iprs_irq_t;

  // Sticky record of which error caused the last device reset.
  typedef struct packed {
    logic watchdog;
    logic uninit_ptr;
    logic illegal_op;
    logic brownout;
    logic trap_lockout;
  } iprs_cause_t;

  // Reset entry sequence.
  typedef enum logic [1:0] {
    IPRS_BOOT_JUMP,
    IPRS_BOOT_TARGET,
    IPRS_RUN
  } iprs_boot_t;

endpackage
`default_nettype wire

//--- iprs_reset_sources.sv
// Error reset sources: detects the five error conditions and records the cause.
`default_nettype none
module iprs_reset_sources
  import iprs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wdt_timeout,
  input wire logic uninit_ptr_use,
  input wire logic illegal_exec,
  input wire logic illegal_flush,
  input wire logic brownout_pin,
  input wire logic [3:0] trap_active,
  input wire iprs_pkg::iprs_cause_t cause_clear,
  output logic error_reset,
  output iprs_pkg::iprs_cause_t reset_cause
);
  import iprs_pkg::*;

  logic bo_meta_r, bo_sync_r;
  logic bo_meta_nxt, bo_sync_nxt;
  logic err_r, err_nxt;
  iprs_cause_t cause_r, cause_nxt, hit;
  logic multi_trap;

  // Brown-out comes from an analog comparator, so it is synchronised first.
  always_comb begin
    bo_meta_nxt = brownout_pin;
    bo_sync_nxt = bo_meta_r;
  end

  // More than one trap in the same cycle is a lockout.
  always_comb begin
    multi_trap = (trap_active & (trap_active - 4'h1)) != 4'h0;
    hit.watchdog = wdt_timeout;
    hit.uninit_ptr = uninit_ptr_use;
    hit.illegal_op = illegal_exec & ~illegal_flush;
    hit.brownout = bo_sync_r;
    hit.trap_lockout = multi_trap;
    // Exactly these five terms reset the device; a new hit beats a clear.
    err_nxt = |hit;
    cause_nxt = (cause_r & ~cause_clear) | hit;
  end

  // Cause bits survive the error reset they describe; only reset_n or cause_clear clears them.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bo_meta_r <= 1'b0;
      bo_sync_r <= 1'b0;
      err_r <= 1'b0;
      cause_r <= '0;
    end else begin
      bo_meta_r <= bo_meta_nxt;
      bo_sync_r <= bo_sync_nxt;
      err_r <= err_nxt;
      cause_r <= cause_nxt;
    end
  end

  assign error_reset = err_r;
  assign reset_cause = cause_r;

endmodule
`default_nettype wire

//--- iprs_ctrl.sv
// Interrupt priority arbiter with reset entry sequence and error reset sources.
//
// Function
// - Every source owns a 3-bit priority field in the low bits of one nibble.
// - Bit 3 of every priority nibble is unused and reads zero.
// - Priority 0 is lowest, 7 highest; levels 1 to 7 serve active interrupts.
// - Equal-priority simultaneous requests are split by vector table position only.
// - Natural order ranks number 0 highest and number 53 lowest.
// - Natural rank equals interrupt number; smaller number wins a tie.
// - User priority always beats natural order.
// - Vector number is interrupt number plus eight.
// - Numbers 1 to 7 are capture 1, compare 1, timers 1-2, capture 2, etc.
// - Numbers 8 to 15 are serial, converter, nonvolatile, two-wire and change sources.
// - Numbers 16 to 25 are external 1, captures, compares, timers, external 2, serial 2.
// - Number 27 is combined CAN, 39 PWM period, 40 encoder, 43 PWM fault A.
// - Reset bypasses the interrupt controller and is never vectored.
// - Reset clears state and starts fetching at program address zero.
// - First word is an absolute jump; its target follows and execution continues there.
// - Exactly five error conditions reset the device.
// - Watchdog expiry resets the device.
// - Using an uninitialised working register as pointer resets the device.
// - Executing an unused opcode traps and resets.
// - A flushed illegal opcode does not trap.
// - Brown-out resets the device; simultaneous traps force a lockout reset.
// - A priority field of zero disables its source.
// - Flags set regardless of enable; only software or a device reset clears them.
// - Only enabled pending requests take part in arbitration.
// - Core is interrupted only when winner level exceeds the CPU level.
`include "iprs_defines.svh"
`default_nettype none
module iprs_ctrl
  import iprs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [53:0] periph_evt,
  input wire logic [2:0] ext_pin,
  input wire logic [53:0] flag_clear,
  input wire logic [53:0] request_enable_registers,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_index,
  input wire logic [15:0] cfg_wdata,
  input wire logic [3:0] cpu_priority_level,
  input wire logic wdt_timeout,
  input wire logic uninit_ptr_use,
  input wire logic illegal_exec,
  input wire logic illegal_flush,
  input wire logic brownout_pin,
  input wire logic [3:0] trap_active,
  input wire iprs_pkg::iprs_cause_t cause_clear,
  input wire logic fetch_ack,
  input wire logic [23:0] fetch_word,
  output logic [53:0] request_flag_registers,
  output logic [15:0] cfg_rdata,
  output iprs_pkg::iprs_irq_t irq,
  output logic core_reset,
  output iprs_pkg::iprs_cause_t reset_cause,
  output logic fetch_req,
  output logic [23:0] fetch_addr,
  output logic core_run,
  output logic [23:0] start_addr
);
  import iprs_pkg::*;

  localparam int NSRC = `IPRS_NUM_SRC;
  localparam int NNIB = `IPRS_NUM_CFG * 4;

  // Error reset detection lives in its own module.
  logic error_reset;
  iprs_cause_t cause_w;

  iprs_reset_sources u_reset_sources (
    .clk(clk),
    .reset_n(reset_n),
    .wdt_timeout(wdt_timeout),
    .uninit_ptr_use(uninit_ptr_use),
    .illegal_exec(illegal_exec),
    .illegal_flush(illegal_flush),
    .brownout_pin(brownout_pin),
    .trap_active(trap_active),
    .cause_clear(cause_clear),
    .error_reset(error_reset),
    .reset_cause(cause_w)
  );

  // A device reset is either the pin reset or an error reset; only the pin reset also clears the pin synchronisers and cause bits.
  logic dev_rst;
  assign dev_rst = !reset_n || error_reset;

  // ---------------- External pin synchronisers ----------------
  logic [2:0] pin_meta_r, pin_sync_r, pin_last_r;
  logic [2:0] pin_meta_nxt, pin_sync_nxt, pin_last_nxt;
  logic [2:0] pin_rise;

  // Two flops before any logic; the edge detector compares the second one with a third.
  always_comb begin
    pin_meta_nxt = ext_pin;
    pin_sync_nxt = pin_meta_r;
    pin_last_nxt = pin_sync_r;
    pin_rise = pin_sync_r & ~pin_last_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
      pin_last_r <= 3'h0;
    end else begin
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
      pin_last_r <= pin_last_nxt;
    end
  end

  // ---------------- Request events per interrupt number ----------------
  // Map pins onto their fixed numbers; all other numbers come from the
  // peripherals in table order, and reserved numbers are forced low.
  logic [53:0] raw_evt;
  logic [53:0] src_evt;

  always_comb begin
    raw_evt = periph_evt;
    raw_evt[`IPRS_EXT0_NUM] = pin_rise[0];
    raw_evt[`IPRS_EXT1_NUM] = pin_rise[1];
    raw_evt[`IPRS_EXT2_NUM] = pin_rise[2];
    src_evt = raw_evt & `IPRS_IMPL_MASK;
  end

  // ---------------- Request flags ----------------
  logic [53:0] flag_r, flag_nxt;

  // One flag per number; a set in the same cycle as a clear wins, so no
  // event is lost while software acknowledges an older one.
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_flag
      always_comb begin
        flag_nxt[gi] = (flag_r[gi] & ~flag_clear[gi]) | src_evt[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      flag_r <= 54'h0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ---------------- Priority configuration ----------------
  logic [2:0] pri_r [NNIB];
  logic [2:0] pri_nxt [NNIB];
  logic [15:0] rdata_r, rdata_nxt;

  // Only the low three bits of each written nibble are stored.
  always_comb begin
    for (int n = 0; n < NNIB; n++) begin
      pri_nxt[n] = pri_r[n];
      if (cfg_wr && (cfg_index == 4'(n / 4))) begin
        pri_nxt[n] = cfg_wdata[(n % 4) * 4 +: 3];
      end
    end
  end

  // Readback of the selected word; the unused top bit of each nibble is 0.
  always_comb begin
    rdata_nxt = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      if (cfg_index < 4'(`IPRS_NUM_CFG)) begin
        rdata_nxt[k * 4 +: 4] = {1'b0, pri_nxt[int'(cfg_index) * 4 + k]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (dev_rst) begin
      for (int n = 0; n < NNIB; n++) begin
        pri_r[n] <= `IPRS_PRI_RST;
      end
      rdata_r <= 16'h0000;
    end else begin
      for (int n = 0; n < NNIB; n++) begin
        pri_r[n] <= pri_nxt[n];
      end
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------- Arbiter ----------------
  logic [53:0] eligible;
  logic [2:0] best_lvl;
  logic [5:0] best_num;
  logic best_hit;

  // Scan from the lowest natural rank upward with a greater-or-equal test,
  // so among equal levels the smallest number is kept last. A full linear
  // scan is a long path but fits easily at this clock rate.
  always_comb begin
    best_lvl = `IPRS_PRI_OFF;
    best_num = 6'h00;
    best_hit = 1'b0;
    for (int s = 0; s < NSRC; s++) begin
      eligible[s] = flag_r[s] & request_enable_registers[s]
                    & (pri_r[s] != `IPRS_PRI_OFF);
    end
    for (int s = NSRC - 1; s >= 0; s--) begin
      if (eligible[s] && (pri_r[s] >= best_lvl)) begin
        best_lvl = pri_r[s];
        best_num = 6'(s);
        best_hit = 1'b1;
      end
    end
  end

  // ---------------- Request to the core ----------------
  iprs_irq_t irq_r, irq_nxt;
  iprs_boot_t boot_r, boot_nxt;

  // No request is offered while booting; the level compare uses the full
  // four-bit CPU level, so trap levels 8 and up mask everything.
  always_comb begin
    irq_nxt.valid = best_hit && (boot_r == IPRS_RUN)
                    && ({1'b0, best_lvl} > cpu_priority_level);
    irq_nxt.vector = best_hit ? (8'(best_num) + `IPRS_VEC_OFS) : 8'h00;
    irq_nxt.level = best_hit ? best_lvl : `IPRS_PRI_OFF;
  end

  // ---------------- Reset entry sequence ----------------
  logic run_r, run_nxt;
  logic [23:0] faddr_r, faddr_nxt;
  logic freq_r, freq_nxt;
  logic [23:0] start_r, start_nxt;
  logic crst_r, crst_nxt;

  // After any reset the core fetches the jump at address zero, then the
  // target word that follows it, and then runs from that target.
  always_comb begin
    boot_nxt = boot_r;
    faddr_nxt = faddr_r;
    freq_nxt = freq_r;
    start_nxt = start_r;
    crst_nxt = 1'b0;
    case (boot_r)
      IPRS_BOOT_JUMP: begin
        if (fetch_ack) begin
          boot_nxt = IPRS_BOOT_TARGET;
          faddr_nxt = `IPRS_TGT_ADDR;
        end
      end
      IPRS_BOOT_TARGET: begin
        if (fetch_ack) begin
          boot_nxt = IPRS_RUN;
          freq_nxt = 1'b0;
          start_nxt = fetch_word;
        end
      end
      IPRS_RUN: begin
        freq_nxt = 1'b0;
      end
      default: begin
        boot_nxt = IPRS_BOOT_JUMP;
        faddr_nxt = `IPRS_BOOT_ADDR;
        freq_nxt = 1'b1;
      end
    endcase
    // The run flag is registered so that core_run leaves a flop directly.
    run_nxt = (boot_nxt == IPRS_RUN);
  end

  // A reset drives the sequence straight to address zero, never through
  // the arbiter, and holds the core in reset for that cycle.
  always_ff @(posedge clk) begin
    if (dev_rst) begin
      boot_r <= IPRS_BOOT_JUMP;
      faddr_r <= `IPRS_BOOT_ADDR;
      freq_r <= 1'b1;
      start_r <= `IPRS_BOOT_ADDR;
      crst_r <= 1'b1;
      run_r <= 1'b0;
      irq_r <= '0;
    end else begin
      boot_r <= boot_nxt;
      faddr_r <= faddr_nxt;
      freq_r <= freq_nxt;
      start_r <= start_nxt;
      crst_r <= crst_nxt;
      run_r <= run_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Every output is a flop.
  assign request_flag_registers = flag_r;
  assign cfg_rdata = rdata_r;
  assign irq = irq_r;
  assign core_reset = crst_r;
  assign reset_cause = cause_w;
  assign fetch_req = freq_r;
  assign fetch_addr = faddr_r;
  assign core_run = run_r;
  assign start_addr = start_r;

endmodule
`default_nettype wire

//--- iprs_ctrl_properties.sv
// Port assertions for the interrupt priority and reset source block.
`include "iprs_defines.svh"
`default_nettype none
module iprs_ctrl_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [53:0] flag_clear,
  input wire logic [53:0] request_enable_registers,
  input wire logic [3:0] cpu_priority_level,
  input wire logic wdt_timeout,
  input wire logic [3:0] trap_active,
  input wire logic fetch_ack,
  input wire logic [23:0] fetch_word,
  input wire logic [53:0] request_flag_registers,
  input wire logic [15:0] cfg_rdata,
  input wire iprs_pkg::iprs_irq_t irq,
  input wire logic core_reset,
  input wire iprs_pkg::iprs_cause_t reset_cause,
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  input wire logic core_run,
  input wire logic [23:0] start_addr
);
  import iprs_pkg::*;
  localparam logic [53:0] IMPL = `IPRS_IMPL_MASK;
  logic [53:0] flag_q;
  logic [53:0] en_q;
  logic [7:0] win;
  // The arbiter answers from last cycle's flags and enables, so keep a copy of them.
  always_ff @(posedge clk) begin
    flag_q <= request_flag_registers;
    en_q <= request_enable_registers;
  end
  // Interrupt number of the offered vector.
  assign win = irq.vector - 8'h08;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_nibble_top_zero: assert property ((cfg_rdata & 16'h8888) == 16'h0000)
    else $error("Priority nibble top bit reads one");
  a_reserved_quiet: assert property ((request_flag_registers & ~IMPL) == 54'h0)
    else $error("Reserved number holds a flag");
  a_vector_winner: assert property (irq.valid |-> win < 8'h36 && flag_q[win] && en_q[win])
    else $error("Offered vector has no enabled pending flag");
  a_level_above_cpu: assert property (irq.valid |-> {1'b0, irq.level} > $past(cpu_priority_level))
    else $error("Request offered at or below the core level");
  a_flag_sticky: assert property (disable iff (!reset_n || core_reset)
    request_flag_registers[3] && !flag_clear[3] |=> request_flag_registers[3])
    else $error("Flag dropped without a clear");
  a_boot_fetch_zero: assert property (disable iff (1'b0)
    !reset_n |=> fetch_req && fetch_addr == 24'h00_0000 && !core_run && !irq.valid)
    else $error("Reset does not fetch from address zero");
  a_jump_target: assert property (fetch_req && fetch_ack && fetch_addr == `IPRS_TGT_ADDR
    |=> core_run && start_addr == $past(fetch_word))
    else $error("Start address is not the jump target");
  a_watchdog_reset: assert property (wdt_timeout |=> reset_cause.watchdog ##1 core_reset)
    else $error("Watchdog expiry did not reset");
  a_trap_lockout: assert property ($countones(trap_active) > 1 |=> reset_cause.trap_lockout)
    else $error("Simultaneous traps did not lock out");
  c_top_level: cover property (irq.valid && irq.level == 3'h7);
  c_rebooted: cover property ($rose(core_run));
  c_lockout: cover property (reset_cause.trap_lockout);
endmodule
bind iprs_ctrl iprs_ctrl_chk u_iprs_ctrl_chk (.clk(clk), .reset_n(reset_n),
  .flag_clear(flag_clear), .request_enable_registers(request_enable_registers),
  .cpu_priority_level(cpu_priority_level), .wdt_timeout(wdt_timeout),
  .trap_active(trap_active), .fetch_ack(fetch_ack), .fetch_word(fetch_word),
  .request_flag_registers(request_flag_registers), .cfg_rdata(cfg_rdata), .irq(irq),
  .core_reset(core_reset), .reset_cause(reset_cause), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr), .core_run(core_run), .start_addr(start_addr));
`default_nettype wire

//--- iprs_core_model.sv
// Behavioural core front end that answers the block's program fetches.
`default_nettype none
module iprs_core_model #(
  // Opcode of the jump word; the value is arbitrary.
  parameter logic [23:0] JUMP_WORD = 24'h3C_0000,
  parameter logic [23:0] TARGET = 24'h00_0120
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] lat,
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  output logic fetch_ack,
  output logic [23:0] fetch_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  // The word changes every cycle outside an answer, so a late sample never passes.
  always @(posedge clk) begin
    if (!reset_n) begin
      fetch_ack <= 1'b0;
      fetch_word <= 24'h55_AAAA;
      wait_r <= 4'h0;
    end else if (fetch_req && !fetch_ack && (wait_r == lat)) begin
      fetch_ack <= 1'b1;
      fetch_word <= (fetch_addr == 24'h00_0000) ? JUMP_WORD : TARGET;
      wait_r <= 4'h0;
    end else begin
      fetch_ack <= 1'b0;
      fetch_word <= ~fetch_word;
      wait_r <= (fetch_req && !fetch_ack) ? (wait_r + 4'h1) : 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- iprs_ctrl_bench.sv
// Self-checking bench for the interrupt priority and reset source block.
`default_nettype none
module iprs_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import iprs_pkg::*;
  localparam logic [23:0] TARGET = 24'h00_0120;
  logic clk = 1'b0, reset_n = 1'b0, cfg_wr = 1'b0, core_reset, ack, freq, run;
  logic [53:0] evt = '0, fclr = '0, en = '0, flags;
  logic [4:0] err_in = '0;
  logic [3:0] trap = '0, cpu = '0, cfg_index = '0, lat = '0;
  logic [2:0] ext_pin = '0;
  logic [15:0] cfg_wdata = '0, cfg_rdata;
  logic [23:0] word, faddr, start;
  iprs_cause_t cclr = '0, cause;
  iprs_irq_t irq;
  int fail_count = 0, check_count = 0;
  always #50 clk = ~clk;
  iprs_ctrl u_iprs_ctrl (.clk(clk), .reset_n(reset_n), .periph_evt(evt), .ext_pin(ext_pin),
    .flag_clear(fclr), .request_enable_registers(en), .cfg_wr(cfg_wr), .cfg_index(cfg_index),
    .cfg_wdata(cfg_wdata), .cpu_priority_level(cpu), .wdt_timeout(err_in[3]),
    .uninit_ptr_use(err_in[2]), .illegal_exec(err_in[1]), .illegal_flush(err_in[0]),
    .brownout_pin(err_in[4]), .trap_active(trap), .cause_clear(cclr), .fetch_ack(ack),
    .fetch_word(word), .request_flag_registers(flags), .cfg_rdata(cfg_rdata), .irq(irq),
    .core_reset(core_reset), .reset_cause(cause), .fetch_req(freq), .fetch_addr(faddr),
    .core_run(run), .start_addr(start));
  iprs_core_model #(.TARGET(TARGET)) u_iprs_core_model (.clk(clk), .reset_n(reset_n),
    .lat(lat), .fetch_req(freq), .fetch_addr(faddr), .fetch_ack(ack), .fetch_word(word));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cfg(input logic [3:0] idx, input logic [15:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_index <= idx;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cyc(1);
  endtask
  // Events and clears are one-cycle pulses; the offered vector follows two edges later.
  task automatic pulse(input logic [53:0] e, input logic [53:0] c);
    @(posedge clk);
    evt <= e;
    fclr <= c;
    @(posedge clk);
    evt <= '0;
    fclr <= '0;
    cyc(2);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (run !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk({run, freq, start}, {1'b1, 1'b0, TARGET});
  endtask
  task automatic t_arb();
    @(posedge clk);
    cfg_index <= 4'h5;
    en <= {54{1'b1}};
    cyc(2);
    chk(cfg_rdata, 16'h4444);
    cfg(4'hE, 16'hFFFF);
    chk(cfg_rdata, 16'h0000);
    cfg(4'h0, 16'h1010);
    cfg(4'hA, 16'hF000);
    chk(cfg_rdata, 16'h7000);
    pulse(54'h800_0000_000A, '0);
    chk(irq, {1'b1, 8'h33, 3'h7});
    pulse('0, 54'h800_0000_0000);
    chk(irq, {1'b1, 8'h09, 3'h1});
    @(posedge clk);
    cpu <= 4'h1;
    cyc(2);
    chk(irq.valid, 1'b0);
    @(posedge clk);
    cpu <= 4'h0;
    en[1] <= 1'b0;
    cyc(2);
    chk(irq, {1'b1, 8'h0B, 3'h1});
    chk(flags, 54'hA);
    cfg(4'h0, 16'h0000);
    cyc(1);
    chk(irq.valid, 1'b0);
    $display("Arbitration test done");
  endtask
  // Only implemented numbers take peripheral events; the pins feed 0, 16 and 23.
  task automatic t_src();
    pulse({54{1'b1}}, '0);
    chk(flags, 54'h980_0B7E_FFFE);
    @(posedge clk);
    ext_pin <= 3'h7;
    cyc(5);
    chk(flags, 54'h980_0BFF_FFFF);
    @(posedge clk);
    ext_pin <= 3'h0;
    pulse('0, {54{1'b1}});
    chk(flags, 54'h0);
    $display("Source map test done");
  endtask
  task automatic t_err(input logic [4:0] e, input logic [3:0] tr, input int hold,
    input logic [4:0] exp);
    @(posedge clk);
    err_in <= e;
    trap <= tr;
    repeat (hold) @(posedge clk);
    err_in <= '0;
    trap <= '0;
    cyc(1);
    chk(cause, exp);
    cyc(1);
    chk(core_reset, exp != 5'h00);
    @(posedge clk);
    cclr <= '1;
    @(posedge clk);
    cclr <= '0;
    cyc(1);
    chk(cause, 5'h00);
    wait_run();
    $display("Error source case done");
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // A hung handshake would stall the run; the whole sequence needs well under this.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wait_run();
    $display("Boot test done");
    t_arb();
    t_src();
    lat <= 4'h3;
    t_err(5'h08, 4'h0, 1, 5'h10);
    t_err(5'h04, 4'h0, 1, 5'h08);
    t_err(5'h02, 4'h0, 1, 5'h04);
    t_err(5'h03, 4'h0, 1, 5'h00);
    t_err(5'h00, 4'h4, 1, 5'h00);
    t_err(5'h00, 4'hC, 1, 5'h01);
    t_err(5'h10, 4'h0, 4, 5'h02);
    summarize();
  end
endmodule
`default_nettype wire
